// ===== rtl/ohci_cs_pkg.sv
package ohci_cs_pkg;

    // register offsets from the base address
    localparam logic [7:0] HOST_CONTROL_OFS = 8'h04;
    localparam logic [7:0] CMD_STATUS_OFS   = 8'h08;

    // field positions
    localparam int RATIO_LSB   = 0;
    localparam int SOC_LSB     = 16;
    localparam int SO_FLAG_BIT = 0;
    localparam int OC_FLAG_BIT = 30;

    // reset values
    localparam logic [1:0]  RATIO_RESET = 2'h0;
    localparam logic [1:0]  SOC_RESET   = 2'h0;
    localparam logic [31:0] CS_RESET    = 32'h0000_0000;

    // timing: soft reset must finish within this, longest time rounds down
    localparam int CLK_PERIOD_NS   = 100;
    localparam int SRST_MAX_NS     = 10000;
    localparam int SRST_MAX_CYCLES = SRST_MAX_NS / CLK_PERIOD_NS;

    // command/status layout
    typedef struct packed {
        logic [13:0] rsvd_hi;
        logic [1:0]  soc;
        logic [11:0] rsvd_lo;
        logic        owner_change_request;
        logic        bulk_filled;
        logic        control_filled;
        logic        soft_reset_cmd;
    } cmd_status_t;

    // events from the list traversal engine, one-cycle pulses
    typedef struct packed {
        logic sched_overrun;   // periodic list not done at end of frame
        logic np_decide;       // about to pick the next nonperiodic ED
        logic ctrl_served;     // a nonempty control ED was processed
        logic ctrl_head;       // engine at head of control list
        logic ctrl_td_found;   // TD found on control list
        logic bulk_head;       // engine at head of bulk list
        logic bulk_td_found;   // TD found on bulk list
        logic owner_done;      // ownership changeover completed
    } list_evt_t;

    typedef enum logic {
        SRST_IDLE,
        SRST_BUSY
    } srst_state_t;

endpackage

// ===== rtl/ohci_command_status_regs.sv
`timescale 1ns/100ps
module ohci_command_status_regs #(
    parameter int SRST_CYCLES = ohci_cs_pkg::SRST_MAX_CYCLES
) (
    input  wire logic                   sys_clk_i,       // 10 MHz host clock
    input  wire logic                   rst_i,           // async, active high
    input  wire logic [7:0]             reg_addr_i,      // byte offset
    input  wire logic                   reg_wr_i,        // write strobe
    input  wire logic                   reg_rd_i,        // read strobe
    input  wire logic [31:0]            reg_wdata_i,     // write data
    output logic      [31:0]            reg_rdata_o,     // read data
    output logic                        reg_rvalid_o,    // read data valid
    input  wire ohci_cs_pkg::list_evt_t evt_i,           // engine events
    output logic                        sel_valid_o,     // decision pulse
    output logic                        sel_ctrl_o,      // 1 control, 0 bulk
    output logic                        ctrl_run_o,      // process control
    output logic                        ctrl_skip_o,     // control list empty
    output logic                        bulk_run_o,      // process bulk
    output logic                        bulk_skip_o,     // bulk list empty
    output logic                        so_flag_set_o,   // set overrun flag
    output logic                        oc_flag_set_o,   // set owner flag
    output logic                        soft_reset_o,    // soft reset busy
    output logic                        suspended_o      // suspended state
);

    // reset must be at least one cycle and still meet its deadline
    if (SRST_CYCLES < 1 || SRST_CYCLES > ohci_cs_pkg::SRST_MAX_CYCLES)
    begin : g_bad_srst
        $error("SRST_CYCLES out of range");
    end

    // limit of control EDs served per bulk ED
    function automatic logic [2:0] ratio_limit(input logic [1:0] code);
        ratio_limit = {1'b0, code} + 3'h1; // 00 1:1, 01 2:1, 10 3:1, 11 4:1
    endfunction

    ohci_cs_pkg::cmd_status_t   cs_reg;
    logic [1:0]                 ratio_reg;
    logic [2:0]                 ctrl_cnt_reg;
    ohci_cs_pkg::srst_state_t   srst_state_reg;
    logic [$clog2(SRST_CYCLES+1)-1:0] srst_cnt_reg;
    logic                       srst_done;
    logic                       wr_ctl;
    logic                       wr_cs;
    logic                       ocr_set;

    // host writes are refused while the soft reset is running; reads are still answered
    assign wr_ctl = reg_wr_i && srst_state_reg == ohci_cs_pkg::SRST_IDLE
                    && reg_addr_i == ohci_cs_pkg::HOST_CONTROL_OFS;
    assign wr_cs  = reg_wr_i && srst_state_reg == ohci_cs_pkg::SRST_IDLE
                    && reg_addr_i == ohci_cs_pkg::CMD_STATUS_OFS;
    assign srst_done = srst_state_reg == ohci_cs_pkg::SRST_BUSY
                       && srst_cnt_reg
                          == ($bits(srst_cnt_reg))'(SRST_CYCLES - 1);
    assign ocr_set = wr_cs && reg_wdata_i[3] && !cs_reg.owner_change_request;

    // service ratio; software must reload it after any reset
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            ratio_reg <= ohci_cs_pkg::RATIO_RESET;
        else if (srst_done)
            ratio_reg <= ohci_cs_pkg::RATIO_RESET;
        else if (wr_ctl)
            ratio_reg <= reg_wdata_i[ohci_cs_pkg::RATIO_LSB +: 2];
    end

    // soft reset sequencer
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            srst_state_reg <= ohci_cs_pkg::SRST_IDLE;
            srst_cnt_reg   <= '0;
        end
        else
        begin
            case (srst_state_reg)
                ohci_cs_pkg::SRST_IDLE:
                begin
                    srst_cnt_reg <= '0;
                    if (cs_reg.soft_reset_cmd)
                        srst_state_reg <= ohci_cs_pkg::SRST_BUSY;
                end
                ohci_cs_pkg::SRST_BUSY:
                begin
                    srst_cnt_reg <= srst_cnt_reg + 1'b1;
                    if (srst_done)
                        srst_state_reg <= ohci_cs_pkg::SRST_IDLE;
                end
                default:
                    srst_state_reg <= ohci_cs_pkg::SRST_IDLE;
            endcase
        end
    end

    // suspend is held from soft reset until software writes host control
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            soft_reset_o <= 1'b0;
            suspended_o  <= 1'b0;
        end
        else
        begin
            soft_reset_o <= srst_state_reg == ohci_cs_pkg::SRST_IDLE
                            ? cs_reg.soft_reset_cmd : !srst_done;
            if (srst_state_reg == ohci_cs_pkg::SRST_IDLE
                && cs_reg.soft_reset_cmd)
                suspended_o <= 1'b1;
            else if (wr_ctl)
                suspended_o <= 1'b0;
        end
    end

    // command/status: write-to-set; hardware set beats clear in one cycle
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            cs_reg <= ohci_cs_pkg::CS_RESET;
        else
        begin
            cs_reg.rsvd_hi <= '0;
            cs_reg.rsvd_lo <= '0;
            if (srst_done)
                cs_reg.soc <= ohci_cs_pkg::SOC_RESET;
            else if (evt_i.sched_overrun)
                cs_reg.soc <= cs_reg.soc + 2'h1;
            // soft reset bit clears only on completion
            if (wr_cs && reg_wdata_i[0])
                cs_reg.soft_reset_cmd <= 1'b1;
            else if (srst_done)
                cs_reg.soft_reset_cmd <= 1'b0;
            if (wr_cs && reg_wdata_i[3])
                cs_reg.owner_change_request <= 1'b1;
            else if (evt_i.owner_done || srst_done)
                cs_reg.owner_change_request <= 1'b0;
            // list heads clear, TD found or software write sets again
            if ((wr_cs && reg_wdata_i[2]) || evt_i.bulk_td_found)
                cs_reg.bulk_filled <= 1'b1;
            else if ((evt_i.bulk_head && cs_reg.bulk_filled) || srst_done)
                cs_reg.bulk_filled <= 1'b0;
            if ((wr_cs && reg_wdata_i[1]) || evt_i.ctrl_td_found)
                cs_reg.control_filled <= 1'b1;
            else if ((evt_i.ctrl_head && cs_reg.control_filled) || srst_done)
                cs_reg.control_filled <= 1'b0;
        end
    end

    // list head decisions and interrupt flag pulses
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bulk_run_o    <= 1'b0;
            bulk_skip_o   <= 1'b0;
            ctrl_run_o    <= 1'b0;
            ctrl_skip_o   <= 1'b0;
            so_flag_set_o <= 1'b0;
            oc_flag_set_o <= 1'b0;
        end
        else
        begin
            bulk_run_o    <= evt_i.bulk_head && cs_reg.bulk_filled;
            bulk_skip_o   <= evt_i.bulk_head && !cs_reg.bulk_filled;
            ctrl_run_o    <= evt_i.ctrl_head && cs_reg.control_filled;
            ctrl_skip_o   <= evt_i.ctrl_head && !cs_reg.control_filled;
            so_flag_set_o <= evt_i.sched_overrun;
            oc_flag_set_o <= ocr_set;
        end
    end

    // control service count; no frame input, so it survives frames
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl_cnt_reg <= '0;
            sel_valid_o  <= 1'b0;
            sel_ctrl_o   <= 1'b0;
        end
        else
        begin
            sel_valid_o <= evt_i.np_decide;
            if (evt_i.np_decide)
            begin
                if (ctrl_cnt_reg < ratio_limit(ratio_reg))
                    sel_ctrl_o <= 1'b1;
                else
                begin
                    sel_ctrl_o   <= 1'b0;
                    ctrl_cnt_reg <= '0;
                end
            end
            else if (evt_i.ctrl_served && ctrl_cnt_reg != 3'h7)
                ctrl_cnt_reg <= ctrl_cnt_reg + 3'h1;
        end
    end

    // register reads: one cycle latency, reads change nothing
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o  <= '0;
            reg_rvalid_o <= 1'b0;
        end
        else
        begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i)
            begin
                case (reg_addr_i)
                    ohci_cs_pkg::HOST_CONTROL_OFS:
                        reg_rdata_o <= {30'h0, ratio_reg};
                    ohci_cs_pkg::CMD_STATUS_OFS:
                        reg_rdata_o <= cs_reg;
                    default:
                        reg_rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// ===== test/ohci_cs_checker_sva.sv
`timescale 1ns/100ps
module ohci_cs_checker #(
    parameter int SRST_CYCLES = ohci_cs_pkg::SRST_MAX_CYCLES
) (
    input wire logic                   sys_clk_i, rst_i, reg_wr_i, reg_rd_i,
    input wire logic [7:0]             reg_addr_i,
    input wire logic [31:0]            reg_wdata_i, reg_rdata_o,
    input wire ohci_cs_pkg::list_evt_t evt_i,
    input wire logic                   reg_rvalid_o, sel_valid_o, bulk_run_o,
    input wire logic                   bulk_skip_o, so_flag_set_o,
    input wire logic                   oc_flag_set_o, soft_reset_o, suspended_o
);
    logic [7:0] busy_cnt;
    // soft reset length kept in a counter, too long for a repetition
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            busy_cnt <= 8'h00;
        else if (soft_reset_o)
            busy_cnt <= busy_cnt + 8'h01;
        else
            busy_cnt <= 8'h00;
    end
    default clocking dc @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence srst_req;
        reg_wr_i && reg_addr_i == ohci_cs_pkg::CMD_STATUS_OFS
        && reg_wdata_i[0] && !soft_reset_o;
    endsequence
    sequence srst_up;
        soft_reset_o && suspended_o;
    endsequence
    a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    a_rdata_holds: assert property (
        !reg_rvalid_o |-> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_overrun_flag: assert property (
        evt_i.sched_overrun |=> so_flag_set_o)
        else $error("overrun flag not raised");
    a_overrun_cause: assert property (
        so_flag_set_o |-> $past(evt_i.sched_overrun))
        else $error("overrun flag without overrun");
    a_decide_answer: assert property (evt_i.np_decide |=> sel_valid_o)
        else $error("no list decision");
    a_bulk_head: assert property (
        evt_i.bulk_head |=> bulk_run_o != bulk_skip_o)
        else $error("bulk head not run or skip");
    a_owner_cause: assert property (
        oc_flag_set_o |-> $past(reg_wr_i && reg_wdata_i[3]
            && reg_addr_i == ohci_cs_pkg::CMD_STATUS_OFS))
        else $error("owner flag without request");
    a_srst_start: assert property (srst_req |-> ##2 srst_up)
        else $error("soft reset did not start");
    a_srst_bounded: assert property (busy_cnt <= SRST_CYCLES)
        else $error("soft reset too long");
endmodule

bind ohci_command_status_regs ohci_cs_checker #(.SRST_CYCLES(SRST_CYCLES))
    i_ohci_cs_checker (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .evt_i(evt_i),
    .reg_rvalid_o(reg_rvalid_o), .sel_valid_o(sel_valid_o),
    .bulk_run_o(bulk_run_o), .bulk_skip_o(bulk_skip_o),
    .so_flag_set_o(so_flag_set_o), .oc_flag_set_o(oc_flag_set_o),
    .soft_reset_o(soft_reset_o), .suspended_o(suspended_o));

// ===== test/tb.sv
`timescale 1ns/100ps
module tb;
    localparam int SRST = 4;
    logic                   sys_clk_i = 1'b0, rst_i = 1'b1;
    logic                   reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0]             reg_addr_i = 8'h00;
    logic [31:0]            reg_wdata_i = 32'h0000_0000, reg_rdata_o;
    ohci_cs_pkg::list_evt_t evt_i = '0;
    logic                   reg_rvalid_o, sel_valid_o, sel_ctrl_o, ctrl_run_o;
    logic                   ctrl_skip_o, bulk_run_o, bulk_skip_o, suspended_o;
    logic                   so_flag_set_o, oc_flag_set_o, soft_reset_o;
    logic [31:0]            exp_cs, wd;
    int                     failures = 0, comparisons = 0, n, k, code;
    ohci_command_status_regs #(.SRST_CYCLES(SRST)) i_ohci_command_status_regs (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .evt_i(evt_i),
        .sel_valid_o(sel_valid_o), .sel_ctrl_o(sel_ctrl_o),
        .ctrl_run_o(ctrl_run_o), .ctrl_skip_o(ctrl_skip_o),
        .bulk_run_o(bulk_run_o), .bulk_skip_o(bulk_skip_o),
        .so_flag_set_o(so_flag_set_o), .oc_flag_set_o(oc_flag_set_o),
        .soft_reset_o(soft_reset_o), .suspended_o(suspended_o));
    // 10 MHz host clock
    always #50 sys_clk_i = ~sys_clk_i;
    // write-to-set: only command bits 3:1 can be set by software here
    function automatic logic [31:0] cs_after(logic [31:0] cur,
                                             logic [31:0] w);
        return cur | (w & 32'h0000_000e);
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one request cycle; returns just after the answering edge
    task automatic bus(input logic wr, rd, input logic [7:0] a,
                       input logic [31:0] d, input ohci_cs_pkg::list_evt_t e);
        @(posedge sys_clk_i);
        reg_wr_i <= wr;
        reg_rd_i <= rd;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        evt_i <= e;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        evt_i <= '0;
        #1;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        bus(1'b0, 1'b1, a, 32'h0000_0000, '0);
        chk("rvalid", 32'h0000_0001, {31'h0, reg_rvalid_o});
        chk(what, exp, reg_rdata_o);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        #(5000 * 100);
        failures++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(20));
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd_chk("cs_reset", 8'h08, 32'h0000_0000);
        rd_chk("hc_reset", 8'h04, 32'h0000_0000);
        exp_cs = 32'h0000_0000;
        // random writes: reserved bits stay zero as software must keep
        // them; soft reset and owner bits are left for their own tests
        for (n = 0; n < 7; n++)
        begin
            wd = (n == 6) ? 32'h0000_0000
                          : ($urandom() & 32'h0003_0006);
            bus(1'b1, 1'b0, 8'h08, wd, '0);
            exp_cs = cs_after(exp_cs, wd);
            rd_chk("cs_set", 8'h08, exp_cs);
        end
        // overruns past the wrap point of the two-bit count
        for (n = 1; n <= 5; n++)
        begin
            bus(1'b0, 1'b0, 8'h00, 32'h0000_0000, 8'h80);
            chk("so_flag", 32'h0000_0001, {31'h0, so_flag_set_o});
            exp_cs[17:16] = n[1:0];
            rd_chk("soc", 8'h08, exp_cs);
        end
        bus(1'b1, 1'b0, 8'h08, 32'h0000_0004, '0);
        bus(1'b0, 1'b0, 8'h00, 32'h0000_0000, 8'h04);
        chk("bulk_run", 32'h0000_0001, {31'h0, bulk_run_o});
        exp_cs[2] = 1'b0;
        rd_chk("bulk_clr", 8'h08, exp_cs);
        bus(1'b0, 1'b0, 8'h00, 32'h0000_0000, 8'h04);
        chk("bulk_skip", 32'h0000_0001, {31'h0, bulk_skip_o});
        bus(1'b0, 1'b0, 8'h00, 32'h0000_0000, 8'h02);
        exp_cs[2] = 1'b1;
        rd_chk("bulk_td", 8'h08, exp_cs);
        // control list head: run, clear, skip, then set again by a TD
        bus(1'b1, 1'b0, 8'h08, 32'h0000_0002, '0);
        bus(1'b0, 1'b0, 8'h00, 32'h0000_0000, 8'h10);
        chk("ctrl_run", 32'h0000_0001, {31'h0, ctrl_run_o});
        exp_cs[1] = 1'b0;
        rd_chk("ctrl_clr", 8'h08, exp_cs);
        bus(1'b0, 1'b0, 8'h00, 32'h0000_0000, 8'h10);
        chk("ctrl_skip", 32'h0000_0001, {31'h0, ctrl_skip_o});
        bus(1'b0, 1'b0, 8'h00, 32'h0000_0000, 8'h08);
        exp_cs[1] = 1'b1;
        rd_chk("ctrl_td", 8'h08, exp_cs);
        rd_chk("unmapped", 8'h0c, 32'h0000_0000);
        // every ratio code: control served until the count reaches the code plus one
        for (code = 0; code < 4; code++)
        begin
            bus(1'b1, 1'b0, 8'h04, code, '0);
            for (k = 0; k <= code + 1; k++)
            begin
                if (k > 0)
                    bus(1'b0, 1'b0, 8'h00, 32'h0000_0000, 8'h20);
                bus(1'b0, 1'b0, 8'h00, 32'h0000_0000, 8'h40);
                chk("sel_valid", 32'h1, {31'h0, sel_valid_o});
                chk("sel_ctrl", {31'h0, k < code + 1},
                    {31'h0, sel_ctrl_o});
            end
        end
        bus(1'b1, 1'b0, 8'h08, 32'h0000_0008, '0);
        chk("oc_flag", 32'h0000_0001, {31'h0, oc_flag_set_o});
        exp_cs[3] = 1'b1;
        rd_chk("owner_req", 8'h08, exp_cs);
        bus(1'b0, 1'b0, 8'h00, 32'h0000_0000, 8'h01);
        exp_cs[3] = 1'b0;
        rd_chk("owner_done", 8'h08, exp_cs);
        // soft reset: bounded busy time, then cleared registers
        bus(1'b1, 1'b0, 8'h08, 32'h0000_0001, '0);
        @(posedge sys_clk_i);
        #1;
        chk("suspend", 32'h0000_0001, {31'h0, suspended_o});
        n = 0;
        while (soft_reset_o === 1'b1 && n < 200)
        begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        chk("srst_len", SRST, n);
        rd_chk("cs_after_srst", 8'h08, 32'h0000_0000);
        rd_chk("hc_after_srst", 8'h04, 32'h0000_0000);
        bus(1'b1, 1'b0, 8'h04, 32'h0000_0002, '0);
        chk("resume", 32'h0000_0000, {31'h0, suspended_o});
        rd_chk("hc_restored", 8'h04, 32'h0000_0002);
        report_and_stop();
    end
endmodule
